/* File: bench/tb.sv */
// self-checking bench for the warm-up counter: avalon-mm master tasks,
// free-running oscillator pins and one task per scenario.
// assumes the owc_pkg map and the one-wait-cycle bus answer.
`timescale 1ns/1ns
module tb;
  import owc_pkg::*;
  logic clk_i, rst_b_i, rd, wr, slow, fast;
  logic [7:0] addr; // byte address
  logic [31:0] wdata, rdata, tmp;
  logic [3:0] be;
  logic [31:0] rdata_o; // dut read data
  logic wait_o, irq_o, pdo_o, pwm_o;
  int errors, check_count, sdiv, fdiv, sticks, fticks, t0;
  owc_warmup_counter #(.ADDR_W(8)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata_o), .avs_waitrequest_o(wait_o),
    .slow_osc_clock_i(slow), .fast_osc_clock_i(fast),
    .warmup_match_irq_o(irq_o), .divider_out_pin_o(pdo_o),
    .pulse_width_pin_o(pwm_o));
  // clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // oscillator pins: slow period 14 clocks, fast 6 clocks, ticks counted
  always @(posedge clk_i) begin
    sdiv <= (sdiv == 6) ? 0 : sdiv + 1;
    fdiv <= (fdiv == 2) ? 0 : fdiv + 1;
    if (sdiv == 6) begin
      slow <= ~slow;
      if (!slow) sticks <= sticks + 1;
    end
    if (fdiv == 2) begin
      fast <= ~fast;
      if (!fast) fticks <= fticks + 1;
    end
  end
  task automatic wrap_up;
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one bus transfer; waitrequest and read data taken at the same rising
  // edge, request released right there
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    int n;
    @(posedge clk_i);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    be <= b;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wait_o === 1'b0) break;
    end
    if (n == 20) begin
      errors++;
      wrap_up();
    end
    rdata = rdata_o;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rreg
  // bounded wait for the interrupt to reach the wanted level
  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_i);
      if (irq_o === lvl) break;
    end
    if (n == lim) begin
      errors++;
      wrap_up();
    end
  endtask : wait_irq
  // bounded wait for a number of slow-pin rising edges
  task automatic wait_slow(input int cnt);
    int n;
    int s0;
    s0 = sticks;
    for (n = 0; n < 20000; n++) begin
      if (sticks - s0 >= cnt) break;
      @(posedge clk_i);
    end
    if (n == 20000) begin
      errors++;
      wrap_up();
    end
  endtask : wait_slow
  // reset values, unmapped read, write with low lane disabled
  task automatic t_reset;
    check({wait_o, irq_o, pdo_o, pwm_o}, 32'h8);
    rreg(OFS_LOW_CTRL); check(rdata, {24'h0, RST_CTRL});
    rreg(OFS_HIGH_CTRL); check(rdata, {24'h0, RST_CTRL});
    rreg(OFS_CMP_HIGH); check(rdata, {24'h0, RST_CMP});
    rreg(OFS_COUNT); check(rdata, 32'h0);
    rreg(8'h3C); check(rdata, 32'h0);
    bus(1'b1, OFS_CMP_HIGH, 8'h5A, 4'hE);
    rreg(OFS_CMP_HIGH); check(rdata, 32'h0);
    // init bits reach the timer pins, then back to quiet
    wreg(OFS_LOW_CTRL, 8'h80);
    wreg(OFS_HIGH_CTRL, 8'h80);
    @(negedge clk_i);
    check({pdo_o, pwm_o}, 32'h3);
    wreg(OFS_LOW_CTRL, RST_CTRL);
    wreg(OFS_HIGH_CTRL, RST_CTRL);
  endtask : t_reset
  // slow variant: 16-bit count, low compare byte ignored
  task automatic t_slow;
    wreg(OFS_LOW_CTRL, 8'h43); // software setting, init zero
    wreg(OFS_HIGH_CTRL, 8'h05); // warm-up selected
    wreg(OFS_CMP_LOW, 8'hFF); // would add 255 ticks if used
    wreg(OFS_CMP_HIGH, 8'h02);
    wreg(OFS_IRQ_MASK, 8'h01);
    check({pdo_o, pwm_o}, 32'h0); // pins stay quiet
    wreg(OFS_HIGH_CTRL, 8'h0D); // slow osc already running
    t0 = sticks;
    rreg(OFS_STATUS); check(rdata, 32'h7);
    wait_slow(300);
    rreg(OFS_COUNT); check(rdata[15:8], 32'h1);
    check(irq_o, 1'b0);
    wait_irq(1'b1, 9000);
    tmp = sticks - t0;
    // a rise one edge before the run write is taken counts but is already in t0
    check(tmp >= 511 && tmp <= 512, 1'b1);
    wreg(OFS_HIGH_CTRL, 8'h05); // handler stops the timer
    rreg(OFS_COUNT); check(rdata < 4, 1'b1); // cleared on match
    rreg(OFS_IRQ_STS); check(rdata, 32'h1);
  endtask : t_slow
  // mask and write-one-clear of the sticky status
  task automatic t_irq;
    wreg(OFS_IRQ_MASK, 8'h00);
    wait_irq(1'b0, 4); check(irq_o, 1'b0);
    rreg(OFS_IRQ_STS); check(rdata, 32'h1);
    wreg(OFS_IRQ_STS, 8'h01);
    rreg(OFS_IRQ_STS); check(rdata, 32'h0);
    wreg(OFS_IRQ_MASK, 8'h01);
    rreg(OFS_IRQ_MASK); check(rdata, 32'h1);
    check(irq_o, 1'b0);
  endtask : t_irq
  // stopped counter holds its value and raises nothing
  task automatic t_hold;
    rreg(OFS_COUNT);
    tmp = rdata;
    rreg(OFS_STATUS); check(rdata, 32'h6);
    wait_slow(30);
    rreg(OFS_COUNT); check(rdata, tmp);
    check(irq_o, 1'b0);
  endtask : t_hold
  // fast variant: counts fast ticks only, slow pin keeps toggling
  task automatic t_fast;
    wreg(OFS_LOW_CTRL, 8'h63); // fast osc assumed enabled
    wreg(OFS_CMP_HIGH, 8'h01);
    wreg(OFS_HIGH_CTRL, 8'h0D);
    t0 = fticks;
    rreg(OFS_STATUS); check(rdata, 32'h5);
    wait_irq(1'b1, 3000);
    tmp = fticks - t0;
    // same one-rise offset as the slow variant
    check(tmp >= 255 && tmp <= 256, 1'b1);
    wreg(OFS_HIGH_CTRL, 8'h05); // stop, then clear the match status
    wreg(OFS_IRQ_STS, 8'h01);
    wait_irq(1'b0, 4); check(irq_o, 1'b0);
  endtask : t_fast
  initial begin
    {rd, wr, slow, fast} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hF;
    errors = 0;
    check_count = 0;
    sdiv = 0;
    fdiv = 0;
    sticks = 0;
    fticks = 0;
    rst_b_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    t_reset();
    t_slow();
    t_irq();
    t_hold();
    t_fast();
    wrap_up();
  end
endmodule : tb

/* File: logic/owc_pkg.sv */
// constants for the oscillator warm-up counter: map, fields, encodings
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
package owc_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_LOW_CTRL = 8'h00; // low_timer_control
  localparam logic [7:0] OFS_HIGH_CTRL = 8'h04; // high_timer_control
  localparam logic [7:0] OFS_CMP_LOW = 8'h08; // compare_low_byte
  localparam logic [7:0] OFS_CMP_HIGH = 8'h0C; // compare_high_byte
  localparam logic [7:0] OFS_COUNT = 8'h10; // live counter, read only
  localparam logic [7:0] OFS_IRQ_STS = 8'h14; // sticky status, write one
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // interrupt mask
  localparam logic [7:0] OFS_STATUS = 8'h1C; // block state, read only

  // field positions inside both timer control bytes
  localparam int unsigned CTRL_INIT_BIT = 7; // out_flop_init
  localparam int unsigned CTRL_SRC_LSB = 4; // source clock field, 3 bits
  localparam int unsigned CTRL_RUN_BIT = 3; // cascade_run_bit (high timer)
  localparam int unsigned CTRL_MODE_LSB = 0; // mode field, 3 bits

  // encodings
  localparam logic [2:0] MODE_CASCADE = 3'h3; // low timer: 16-bit cascade
  localparam logic [2:0] MODE_WARMUP = 3'h5; // high timer: warm-up counter
  localparam logic [2:0] SRC_SLOW = 3'h4; // low timer source: slow osc

  // status bit positions
  localparam int unsigned STS_MATCH_BIT = 0; // warm-up match event
  localparam int unsigned ST_RUN_BIT = 0; // counter running
  localparam int unsigned ST_VARIANT_BIT = 1; // 1: slow variant selected
  localparam int unsigned ST_WARMUP_BIT = 2; // warm-up mode configured

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;

  // oscillator rates and the resulting warm-up spans
  localparam int unsigned SLOW_OSC_HZ = 32768;
  localparam int unsigned FAST_OSC_HZ = 16000000;
  localparam logic [15:0] WARM_MIN_CMP = 16'h0100; // shortest setting
  localparam logic [15:0] WARM_MAX_CMP = 16'hFF00; // longest setting
  localparam real SLOW_MIN_MS = 7.81; // slow variant at minimum setting
  localparam real SLOW_MAX_S = 1.99; // slow variant at maximum setting
  localparam real FAST_MIN_US = 16.0; // fast variant at minimum setting
  localparam real FAST_MAX_MS = 4.08; // fast variant at maximum setting

  // synchroniser depth for oscillator pins
  localparam int unsigned SYNC_STAGES = 2;

endpackage : owc_pkg

/* File: logic/owc_warmup_counter.sv */
// oscillator warm-up counter: two cascaded 8-bit timers as one 16-bit
// up-counter, clocked by oscillator ticks, with avalon-mm registers.
// assumes a 125 mhz clk_i, oscillator clocks arriving as raw pins, and a
// master that holds its request until waitrequest is seen low.
//
// Summary of operation
// (RULE_01) two 8-bit timers chained as 16-bit counter
// (RULE_02) slow and fast warm-up variants supported
// (RULE_03) software keeps output flop inits at zero
// (RULE_04) match uses upper compare byte only
// (RULE_05) run bit starts, clearing it stops
// (RULE_06) on match clear counter, raise interrupt
// (RULE_07) slow variant times slow oscillator start-up
// (RULE_08) software enables slow oscillator before slow warm-up
// (RULE_09) after slow match: stop, select slow, fast off
// (RULE_10) software enables fast oscillator before fast warm-up
// (RULE_11) after fast match: stop, select fast, slow off
// (RULE_12) slow: 0100H about 7.81ms, FF00H 1.99s
// (RULE_13) fast: 0100H 16us, FF00H 4.08ms
// (RULE_14) software writes 05H to high control
// (RULE_15) slow warm-up low control value is 43H
// (RULE_16) stopped counter holds, raises no match

`timescale 1ns/1ns

module owc_warmup_counter
  import owc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8 // avalon byte address width
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic slow_osc_clock_i,
  input wire logic fast_osc_clock_i,
  output logic warmup_match_irq_o,
  output logic divider_out_pin_o,
  output logic pulse_width_pin_o
);

  // the decode needs all eight offset bits, the upper ones must be zero;
  // refused at elaboration so a bad width never builds
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
    $error("owc_warmup_counter: ADDR_W must be 8 to 32");
  end

  // one-hot counter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, // stopped or not in warm-up mode
    ST_COUNT = 2'b10 // cascade counting oscillator ticks
  } owc_state_type;

  // all state of the block
  typedef struct packed {
    logic [7:0] low_ctrl; // low_timer_control
    logic [7:0] high_ctrl; // high_timer_control
    logic [7:0] cmp_low; // compare_low_byte, stored only
    logic [7:0] cmp_high; // compare_high_byte
    logic [15:0] cnt; // cascaded up-counter
    logic sts_match; // sticky match status
    logic msk_match; // mask for the match status
    owc_state_type st; // counter state
    logic slow_s1; // slow pin, first sync flop
    logic slow_s2; // slow pin, second sync flop
    logic slow_prev; // slow pin, edge history
    logic fast_s1; // fast pin, first sync flop
    logic fast_s2; // fast pin, second sync flop
    logic fast_prev; // fast pin, edge history
    logic match; // one-cycle match pulse
    logic irq; // interrupt output flop
    logic waitreq; // avalon waitrequest flop
    logic [31:0] rdata; // avalon readdata flop
    logic pin_low; // low timer output flop
    logic pin_high; // high timer output flop
  } owc_regs_type;

  owc_regs_type r_q; // registered state
  owc_regs_type r_d; // next state

  // true when the byte address hits the given word offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  // combinational helpers
  logic slow_tick; // rising edge of synchronised slow oscillator
  logic fast_tick; // rising edge of synchronised fast oscillator
  logic src_slow; // low timer sourced from the slow oscillator
  logic tick; // counting tick from the selected source
  logic warmup; // both timers set up for warm-up cascade
  logic run; // cascade_run_bit
  logic [15:0] target; // match value, lower byte forced to zero
  logic [15:0] cnt_inc; // counter plus one
  logic wr_fire; // write taken at this edge
  logic lane0; // low byte lane enabled
  logic clr_match; // software clears the sticky match bit
  logic [31:0] rd_word; // read mux

  // next-state logic: sync, count, bus, interrupt
  always_comb begin
    r_d = r_q;
    // two-flop synchronisers; only the second flop feeds the edge detect
    r_d.slow_s1 = slow_osc_clock_i;
    r_d.slow_s2 = r_q.slow_s1;
    r_d.slow_prev = r_q.slow_s2;
    r_d.fast_s1 = fast_osc_clock_i;
    r_d.fast_s2 = r_q.fast_s1;
    r_d.fast_prev = r_q.fast_s2;
    slow_tick = r_q.slow_s2 & ~r_q.slow_prev;
    fast_tick = r_q.fast_s2 & ~r_q.fast_prev;

    // source select picks the variant: slow ticks time the slow start-up
    src_slow = (r_q.low_ctrl[CTRL_SRC_LSB +: 3] == SRC_SLOW); // [RULE_02]
    tick = src_slow ? slow_tick : fast_tick; // [RULE_07]
    warmup = (r_q.high_ctrl[CTRL_MODE_LSB +: 3] == MODE_WARMUP) &&
             (r_q.low_ctrl[CTRL_MODE_LSB +: 3] == MODE_CASCADE);
    run = r_q.high_ctrl[CTRL_RUN_BIT];
    // spans scale with the source: 0100H is 256 ticks, FF00H 65280, so
    // the slow source spans milliseconds to seconds, the fast one micro-
    // to milliseconds; only whole steps of 256 ticks can be set
    // lower compare byte never takes part in the match
    target = {r_q.cmp_high, 8'h00}; // [RULE_04]
    cnt_inc = r_q.cnt + 16'h0001; // [RULE_01]
    r_d.match = 1'b0;

    // counter state machine
    case (r_q.st)
      ST_IDLE: begin
        // counter holds, no match while stopped
        if (run && warmup) begin
          r_d.st = ST_COUNT; // [RULE_05]
        end
      end
      ST_COUNT: begin
        if (!(run && warmup)) begin
          r_d.st = ST_IDLE; // [RULE_05] [RULE_16]
        end else if (tick) begin
          if (cnt_inc == target) begin // [RULE_12] [RULE_13]
            // clear and flag; keeps running until software stops it
            r_d.cnt = 16'h0000; // [RULE_06]
            r_d.match = 1'b1; // [RULE_06]
          end else begin
            r_d.cnt = cnt_inc; // [RULE_01]
          end
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // bus: one wait cycle, the write lands on the edge waitrequest is low
    wr_fire = avs_write_i && !r_q.waitreq;
    lane0 = avs_byteenable_i[0];
    clr_match = 1'b0;
    if (wr_fire && lane0) begin
      if (hit(avs_address_i, OFS_LOW_CTRL)) begin
        r_d.low_ctrl = avs_writedata_i[7:0]; // [RULE_15]
      end else if (hit(avs_address_i, OFS_HIGH_CTRL)) begin
        r_d.high_ctrl = avs_writedata_i[7:0]; // [RULE_14]
      end else if (hit(avs_address_i, OFS_CMP_LOW)) begin
        r_d.cmp_low = avs_writedata_i[7:0];
      end else if (hit(avs_address_i, OFS_CMP_HIGH)) begin
        r_d.cmp_high = avs_writedata_i[7:0];
      end else if (hit(avs_address_i, OFS_IRQ_STS)) begin
        clr_match = avs_writedata_i[STS_MATCH_BIT];
      end else if (hit(avs_address_i, OFS_IRQ_MASK)) begin
        r_d.msk_match = avs_writedata_i[STS_MATCH_BIT];
      end
    end

    // sticky match bit: a match in the clearing cycle wins
    r_d.sts_match = (r_q.sts_match & ~clr_match) | r_d.match; // [RULE_06]
    r_d.irq = r_d.sts_match & r_d.msk_match;

    // timer pins follow the init bits; zero keeps them quiet in warm-up
    r_d.pin_low = r_d.low_ctrl[CTRL_INIT_BIT];
    r_d.pin_high = r_d.high_ctrl[CTRL_INIT_BIT];

    // read mux; unmapped offsets read zero
    rd_word = 32'h0000_0000;
    if (hit(avs_address_i, OFS_LOW_CTRL)) begin
      rd_word[7:0] = r_q.low_ctrl;
    end else if (hit(avs_address_i, OFS_HIGH_CTRL)) begin
      rd_word[7:0] = r_q.high_ctrl;
    end else if (hit(avs_address_i, OFS_CMP_LOW)) begin
      rd_word[7:0] = r_q.cmp_low;
    end else if (hit(avs_address_i, OFS_CMP_HIGH)) begin
      rd_word[7:0] = r_q.cmp_high;
    end else if (hit(avs_address_i, OFS_COUNT)) begin
      rd_word[15:0] = r_q.cnt;
    end else if (hit(avs_address_i, OFS_IRQ_STS)) begin
      rd_word[STS_MATCH_BIT] = r_q.sts_match;
    end else if (hit(avs_address_i, OFS_IRQ_MASK)) begin
      rd_word[STS_MATCH_BIT] = r_q.msk_match;
    end else if (hit(avs_address_i, OFS_STATUS)) begin
      rd_word[ST_RUN_BIT] = (r_q.st == ST_COUNT);
      rd_word[ST_VARIANT_BIT] = src_slow;
      rd_word[ST_WARMUP_BIT] = warmup;
    end

    // handshake: first cycle of a request captures data and drops wait
    if ((avs_read_i || avs_write_i) && r_q.waitreq) begin
      r_d.waitreq = 1'b0;
      r_d.rdata = avs_read_i ? rd_word : 32'h0000_0000;
    end else begin
      r_d.waitreq = 1'b1;
    end
  end

  // state register; waitrequest idles high so no request slips through
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q <= '0;
      r_q.low_ctrl <= RST_CTRL;
      r_q.high_ctrl <= RST_CTRL;
      r_q.cmp_low <= RST_CMP;
      r_q.cmp_high <= RST_CMP;
      r_q.st <= ST_IDLE;
      r_q.waitreq <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops; timer pins copy the init bits as is
  assign avs_readdata_o = r_q.rdata;
  assign avs_waitrequest_o = r_q.waitreq;
  assign warmup_match_irq_o = r_q.irq;
  assign divider_out_pin_o = r_q.pin_low;
  assign pulse_width_pin_o = r_q.pin_high;

  // checks on the counting core
  AST_HOLD_STOPPED: assert property ( // [RULE_16]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_IDLE) |=> ($stable(r_q.cnt) && !r_q.match))
    else $error("counter moved or matched while stopped");

  AST_START: assert property ( // [RULE_05]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_IDLE && run && warmup) |=> (r_q.st == ST_COUNT))
    else $error("run bit did not start the counter");

  AST_STOP: assert property ( // [RULE_05]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_COUNT && !run) |=> (r_q.st == ST_IDLE))
    else $error("clearing the run bit did not stop the counter");

  AST_STEP: assert property ( // [RULE_01]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_COUNT && run && warmup && tick && cnt_inc != target)
    |=> (r_q.cnt == $past(r_q.cnt) + 16'h0001))
    else $error("cascade did not advance by one on a tick");

  AST_MATCH_CLEAR: assert property ( // [RULE_06]
    @(posedge clk_i) disable iff (!rst_b_i)
    r_q.match |-> (r_q.cnt == 16'h0000 && r_q.sts_match)
    ##1 (r_q.irq == r_q.msk_match || !r_q.sts_match))
    else $error("match did not clear the counter and flag");

  AST_UPPER_ONLY: assert property ( // [RULE_04]
    @(posedge clk_i) disable iff (!rst_b_i)
    r_q.match |-> ($past(r_q.cnt[7:0]) == 8'hFF &&
                   $past(r_q.cnt[15:8]) + 8'h01 == $past(r_q.cmp_high)))
    else $error("match fired away from the upper compare byte");

  AST_VARIANT_SRC: assert property ( // [RULE_02] [RULE_07]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_COUNT && run && warmup && src_slow && !slow_tick)
    |=> $stable(r_q.cnt))
    else $error("slow variant counted without a slow tick");

  AST_IRQ_LEVEL: assert property ( // [RULE_06]
    @(posedge clk_i) disable iff (!rst_b_i)
    r_q.irq == (r_q.sts_match && r_q.msk_match))
    else $error("unmasked status without interrupt");

  AST_ONE_WAIT: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ((avs_read_i || avs_write_i) && r_q.waitreq) |=> !r_q.waitreq
    ##1 r_q.waitreq)
    else $error("waitrequest did not drop for exactly one cycle");

  // a compare hit on a tick clears and flags in one step
  AST_MATCH_EVENT: assert property ( // [RULE_06] [RULE_12] [RULE_13]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_COUNT && run && warmup && tick && cnt_inc == target)
    |=> (r_q.match && r_q.sts_match && r_q.cnt == 16'h0000))
    else $error("compare hit did not clear the counter and flag");

  // no run bit or no warm-up setup: counter frozen, no event
  AST_HALT_QUIET: assert property ( // [RULE_16] [RULE_05]
    @(posedge clk_i) disable iff (!rst_b_i)
    !(run && warmup) |=> (!r_q.match && $stable(r_q.cnt)))
    else $error("counter moved or matched without run and warm-up");

  // the fast variant only advances on a fast tick
  AST_FAST_SRC: assert property ( // [RULE_02]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_COUNT && run && warmup && !src_slow && !fast_tick)
    |=> $stable(r_q.cnt))
    else $error("fast variant counted without a fast tick");

  // writing one clears the flag unless a match lands in the same cycle
  AST_W1C: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clr_match && !r_d.match) |=> !r_q.sts_match)
    else $error("write-one did not clear the match status");

  // the flag stays until software clears it
  AST_STICKY: assert property ( // [RULE_06]
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.sts_match && !clr_match) |=> r_q.sts_match)
    else $error("match status dropped without a clear");

  // pins mirror the init bits, so zero bits keep them quiet
  AST_PINS_FOLLOW: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.pin_low == r_q.low_ctrl[CTRL_INIT_BIT] &&
     r_q.pin_high == r_q.high_ctrl[CTRL_INIT_BIT]))
    else $error("timer pin does not follow its init bit");

  // no request, no completion: waitrequest idles high
  AST_WAIT_IDLE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !(avs_read_i || avs_write_i) |=> r_q.waitreq)
    else $error("waitrequest dropped with no request");

  // read data is the register state seen when the request was taken
  AST_READ_CAPTURE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (avs_read_i && r_q.waitreq) |=> (avs_readdata_o == $past(rd_word)))
    else $error("read data differs from the addressed register");

  // state register only ever holds one of the two codes
  AST_STATE_LEGAL: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (r_q.st == ST_IDLE || r_q.st == ST_COUNT))
    else $error("counter state left its one-hot codes");

endmodule : owc_warmup_counter
